// *** tacd_pkg.sv ***
// constants and types for the touch converter control byte decoder
package tacd_pkg;
    // register byte offsets
    localparam logic [7:0] TACD_CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] TACD_STATUS_OFFSET = 8'h04;
    localparam logic [7:0] TACD_COMMAND_OFFSET = 8'h08;
    localparam logic [7:0] TACD_RESULT_OFFSET = 8'h0c;
    localparam logic [31:0] TACD_CONFIG_RESET = 32'h0000_0001;
    localparam int TACD_CONFIG_ENABLE_POS = 0;
    // control byte fields
    localparam int TACD_START_POS = 7;
    localparam int TACD_CHANNEL_MSB = 6;
    localparam int TACD_CHANNEL_LSB = 4;
    localparam int TACD_RESOLUTION_POS = 3;
    localparam int TACD_REFMODE_POS = 2;
    localparam int TACD_REFPOWER_POS = 1;
    localparam int TACD_LOWPOWER_POS = 0;
    // serial clock counts
    localparam logic [3:0] TACD_BYTE_BITS = 4'h8;
    localparam logic [3:0] TACD_ACQUIRE_AFTER = 4'h5;
    localparam logic [3:0] TACD_FULL_BITS = 4'hc;
    localparam logic [3:0] TACD_SHORT_BITS = 4'h8;
    localparam logic [3:0] TACD_OVERLAP_LEAD = 4'h5;
    // panel measurement channels
    localparam logic [2:0] TACD_CH_Y = 3'h1;
    localparam logic [2:0] TACD_CH_Z1 = 3'h3;
    localparam logic [2:0] TACD_CH_Z2 = 3'h4;
    localparam logic [2:0] TACD_CH_X = 3'h5;
    // reset values
    localparam logic TACD_LOWPOWER_RESET = 1'b1;
    localparam logic TACD_REFPOWER_RESET = 1'b0;
    typedef enum logic [1:0] {TACD_RX_HUNT, TACD_RX_COLLECT, TACD_RX_ACQ_END} tacd_rx_type;
    typedef enum logic [1:0] {TACD_CV_IDLE, TACD_CV_BUSY, TACD_CV_SHIFT} tacd_cv_type;
endpackage

// *** tacd_decoder.sv ***
// serial control byte decoder, power and touch alert control, apb status
`timescale 1ns/1ns
//
// Overview of operation
// R1: ignore serial input until high start bit
// R2: byte is start, channel, resolution, refmode, power
// R3: channel and refmode steer mux, drivers, reference
// R4: resolution bit low 12 bits, high 8
// R5: refmode high single-ended, low differential
// R6: differential reference from drivers, else reference pin
// R7: new byte every 15th/11th serial clock
// R8: host uses differential only for panel channels; the bench sends 8'hde, single-ended on channel X
// R9: reference and converter powered independently
// R10: reference power latched when busy rises
// R11: host sends another byte to drop reference
// R12: host waits after reference power-up
// R13: power 00 auto power-down, alert on, Y-minus grounded
// R14: power 01 reference off, converter on, alert off
// R15: power 10 reference on, converter off, alert on
// R16: power 11 all on, alert off
// R17: power-down grounds Y, x-plus pulled up drives alert
// R18: panel measurement: detach pull-up, alert low
// R19: other measurements: alert held high
// R20: low power bit set keeps touch detection off
// R21: alert re-armed at end of conversion
// R22: acquire three clocks, then convert twelve
// R23: chip select high aborts, reference unchanged
// R24: result shifted out msb first on falling edges
module tacd_decoder
    import tacd_pkg::*;
#(
    parameter int RESULT_WIDTH = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pclk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock_in,
    input wire logic chip_select_n_in,
    input wire logic serial_data_in,
    input wire logic xplus_sense_in,
    input wire logic [11:0] conv_result_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic busy_out,
    output logic busy_oe,
    output logic touch_alert_out,
    output logic acquire_out,
    output logic convert_out,
    output logic [2:0] channel_select_bits,
    output logic reference_mode_bit,
    output logic resolution_8bit,
    output logic reference_power_on,
    output logic converter_power_on,
    output logic panel_drivers_on,
    output logic reference_from_drivers,
    output logic y_minus_ground,
    output logic xplus_pullup_on
);
    // only the 12-bit result path is built; refuse anything else at elaboration
    if (RESULT_WIDTH != 12) begin : g_width_check
        $error("tacd_decoder serves a 12-bit result only");
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: first stage feeds only the second
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sclk_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // serial clock bit resets to its idle low level: no false edge
            sync1 <= 4'he;
            sync2 <= 4'he;
            sclk_prev <= 1'b0;
        end else if (pclk_en) begin
            sync1 <= {xplus_sense_in, serial_data_in, chip_select_n_in, serial_clock_in};
            sync2 <= sync1;
            sclk_prev <= sync2[0];
        end
    end
    logic cs_active;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic [31:0] config_reg;
    assign cs_active = !sync2[1] && config_reg[TACD_CONFIG_ENABLE_POS];
    assign sclk_rise = sync2[0] && !sclk_prev && cs_active;
    assign sclk_fall = !sync2[0] && sclk_prev && cs_active;
    assign din = sync2[2];

    ////////////////////////////////////////////////////////////////////////
    // command receiver
    tacd_rx_type rx_state;
    tacd_cv_type cv_state;
    logic [7:0] rx_shift;
    logic [3:0] rx_count;
    logic [3:0] cv_count;
    logic [3:0] cv_bits;
    logic start_ok;
    // overlap: next start allowed once enough result bits are out
    assign cv_bits = resolution_8bit ? TACD_SHORT_BITS : TACD_FULL_BITS;
    assign start_ok = (cv_state == TACD_CV_IDLE) ||
        (cv_state == TACD_CV_SHIFT && cv_count >= cv_bits - TACD_OVERLAP_LEAD); // see R7
    logic load;
    assign load = (rx_state == TACD_RX_ACQ_END) && sclk_fall;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= TACD_RX_HUNT;
            rx_shift <= 8'h00;
            rx_count <= 4'h0;
        end else if (pclk_en) begin
            if (!cs_active) begin
                rx_state <= TACD_RX_HUNT; // see R23
                rx_count <= 4'h0;
            end else begin
                unique case (rx_state)
                    TACD_RX_HUNT: begin
                        // low bits before the start marker are dropped
                        if (sclk_rise && din && start_ok) begin // see R1
                            rx_state <= TACD_RX_COLLECT;
                            rx_shift <= 8'h01;
                            rx_count <= 4'h1;
                        end
                    end
                    TACD_RX_COLLECT: begin
                        if (sclk_rise) begin
                            rx_shift <= {rx_shift[6:0], din}; // see R2
                            rx_count <= rx_count + 4'h1;
                            if (rx_count == TACD_BYTE_BITS - 4'h1) begin
                                rx_state <= TACD_RX_ACQ_END;
                            end
                        end
                    end
                    TACD_RX_ACQ_END: begin
                        if (sclk_fall) begin
                            rx_state <= TACD_RX_HUNT;
                            rx_count <= 4'h0;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter sequencer and result shifter
    logic [11:0] out_shift;
    logic [7:0] cmd_last;
    logic [11:0] result_last;
    logic eoc;
    assign eoc = (cv_state == TACD_CV_SHIFT) && sclk_fall && (cv_count == cv_bits - 4'h1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cv_state <= TACD_CV_IDLE;
            cv_count <= 4'h0;
            out_shift <= 12'h000;
            serial_data_out <= 1'b0;
            cmd_last <= 8'h00;
            result_last <= 12'h000;
        end else if (pclk_en) begin
            if (!cs_active) begin
                cv_state <= TACD_CV_IDLE; // see R23
                cv_count <= 4'h0;
                serial_data_out <= 1'b0;
            end else if (load) begin
                // busy rises: capture the sample and the command
                cv_state <= TACD_CV_BUSY; // see R22
                cv_count <= 4'h0;
                cmd_last <= rx_shift;
                result_last <= conv_result_in;
                out_shift <= conv_result_in;
                serial_data_out <= 1'b0;
            end else if (sclk_fall) begin
                unique case (cv_state)
                    TACD_CV_IDLE: begin
                        serial_data_out <= 1'b0;
                    end
                    TACD_CV_BUSY, TACD_CV_SHIFT: begin
                        serial_data_out <= out_shift[11]; // see R24
                        out_shift <= {out_shift[10:0], 1'b0};
                        cv_count <= cv_count + 4'h1;
                        if (eoc) begin
                            cv_state <= TACD_CV_IDLE; // see R4
                        end else begin
                            cv_state <= TACD_CV_SHIFT;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power, reference latch and touch alert arming
    logic low_power_last;
    logic alert_armed;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_power_on <= TACD_REFPOWER_RESET;
            low_power_last <= TACD_LOWPOWER_RESET;
        end else if (pclk_en && load) begin
            // reference follows only at busy rise, not at chip select
            reference_power_on <= rx_shift[TACD_REFPOWER_POS]; // see R9 R10
            low_power_last <= rx_shift[TACD_LOWPOWER_POS]; // see R13 R14 R15 R16
        end
    end
    // measurement start disarms; end of conversion rearms if low power bit clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_armed <= 1'b0;
        end else if (pclk_en) begin
            if (eoc) begin
                alert_armed <= !low_power_last; // see R20 R21
            end else if (!cs_active && rx_state != TACD_RX_HUNT) begin
                alert_armed <= !low_power_last;
            end else if (rx_state == TACD_RX_COLLECT && rx_count == TACD_ACQUIRE_AFTER) begin
                alert_armed <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered analog control outputs
    logic next_acquire;
    logic next_convert;
    logic [2:0] next_channel;
    logic next_refmode;
    logic panel_channel;
    logic [7:0] acq_view;
    always_comb begin
        // bits received so far moved to their places in the byte
        acq_view = rx_shift << (4'h8 - rx_count);
        next_acquire = (rx_state == TACD_RX_COLLECT && rx_count >= TACD_ACQUIRE_AFTER)
            || rx_state == TACD_RX_ACQ_END; // see R22
        next_convert = cv_state != TACD_CV_IDLE;
        // while acquiring, the arriving byte steers the mux
        if (next_acquire) begin
            next_channel = acq_view[TACD_CHANNEL_MSB:TACD_CHANNEL_LSB]; // see R3
            next_refmode = (rx_count > TACD_ACQUIRE_AFTER) ?
                acq_view[TACD_REFMODE_POS] : cmd_last[TACD_REFMODE_POS];
        end else begin
            next_channel = cmd_last[TACD_CHANNEL_MSB:TACD_CHANNEL_LSB]; // see R3
            next_refmode = cmd_last[TACD_REFMODE_POS];
        end
        panel_channel = next_channel == TACD_CH_X || next_channel == TACD_CH_Y ||
            next_channel == TACD_CH_Z1 || next_channel == TACD_CH_Z2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acquire_out <= 1'b0;
            convert_out <= 1'b0;
            channel_select_bits <= 3'h0;
            reference_mode_bit <= 1'b0;
            resolution_8bit <= 1'b0;
            converter_power_on <= 1'b1;
            panel_drivers_on <= 1'b0;
            reference_from_drivers <= 1'b0;
            y_minus_ground <= 1'b0;
            xplus_pullup_on <= 1'b0;
            touch_alert_out <= 1'b1;
            busy_out <= 1'b0;
        end else if (pclk_en) begin
            acquire_out <= next_acquire;
            convert_out <= next_convert;
            channel_select_bits <= next_channel;
            reference_mode_bit <= next_refmode; // see R5
            resolution_8bit <= cmd_last[TACD_RESOLUTION_POS]; // see R4
            converter_power_on <= low_power_last || next_acquire || next_convert; // see R13
            // single-ended drops drivers once the sample is held
            panel_drivers_on <= panel_channel &&
                (next_acquire || (next_convert && !next_refmode)); // see R22
            reference_from_drivers <= !next_refmode; // see R6
            y_minus_ground <= alert_armed; // see R17
            xplus_pullup_on <= alert_armed && !next_acquire && !next_convert; // see R18
            if (alert_armed && !next_acquire && !next_convert) begin
                touch_alert_out <= sync2[3]; // see R17
            end else if (panel_channel) begin
                touch_alert_out <= 1'b0; // see R18
            end else begin
                touch_alert_out <= 1'b1; // see R19
            end
            busy_out <= cv_state == TACD_CV_BUSY;
        end
    end
    assign serial_data_oe = cs_active;
    assign busy_oe = cs_active;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    logic mapped;
    assign mapped = paddr == TACD_CONFIG_OFFSET || paddr == TACD_STATUS_OFFSET ||
        paddr == TACD_COMMAND_OFFSET || paddr == TACD_RESULT_OFFSET;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg <= TACD_CONFIG_RESET;
        end else if (pclk_en && psel && penable && pwrite && paddr == TACD_CONFIG_OFFSET) begin
            config_reg <= {31'h0, pwdata[TACD_CONFIG_ENABLE_POS]};
        end
    end
    // read data settles in the setup cycle so the access edge sees a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (pclk_en && psel && !penable) begin
            unique case (paddr)
                TACD_CONFIG_OFFSET: prdata <= config_reg;
                TACD_STATUS_OFFSET: prdata <= {24'h0, alert_armed, reference_power_on,
                    low_power_last, cs_active, 2'(cv_state), 2'(rx_state)};
                TACD_COMMAND_OFFSET: prdata <= {24'h0, cmd_last};
                TACD_RESULT_OFFSET: prdata <= {20'h0, result_last};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule

// *** tacd_decoder_checker.sv ***
// port level assertions for the control byte decoder
`timescale 1ns/1ns
module tacd_decoder_checker
    import tacd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pslverr,
    input wire logic chip_select_n_in,
    input wire logic serial_data_oe,
    input wire logic busy_out,
    input wire logic touch_alert_out,
    input wire logic acquire_out,
    input wire logic convert_out,
    input wire logic [2:0] channel_select_bits,
    input wire logic reference_mode_bit,
    input wire logic reference_power_on,
    input wire logic reference_from_drivers
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic panel;
    // touch panel channels hold the alert low while converting
    assign panel = channel_select_bits inside {TACD_CH_Y, TACD_CH_Z1, TACD_CH_Z2, TACD_CH_X};
    property p_refsrc; convert_out |-> reference_from_drivers != reference_mode_bit; endproperty
    a_refsrc: assert property (p_refsrc) else $error("reference source wrong");
    property p_slverr; psel && penable && paddr > 8'h0c |-> pslverr; endproperty
    a_slverr: assert property (p_slverr) else $error("no error on unmapped");
    property p_busy; $rose(busy_out) |-> convert_out && $past(acquire_out); endproperty
    a_busy: assert property (p_busy) else $error("busy not after acquire");
    property p_acq; $rose(acquire_out) |-> acquire_out [*8]; endproperty
    a_acq: assert property (p_acq) else $error("acquire too short");
    property p_abort; $rose(chip_select_n_in) |-> ##[1:6] !convert_out && !acquire_out; endproperty
    a_abort: assert property (p_abort) else $error("conversion not abandoned");
    property p_refkeep; chip_select_n_in [*4] |=> $stable(reference_power_on); endproperty
    a_refkeep: assert property (p_refkeep) else $error("reference moved");
    property p_oe; chip_select_n_in [*5] |-> !serial_data_oe; endproperty
    a_oe: assert property (p_oe) else $error("data out enabled");
    property p_panel; convert_out && panel |-> !touch_alert_out; endproperty
    a_panel: assert property (p_panel) else $error("alert not low");
    property p_other; convert_out && !panel |-> touch_alert_out; endproperty
    a_other: assert property (p_other) else $error("alert not high");
    // the mux setting taken during acquisition carries into the hold
    property p_hold; $fell(acquire_out) && convert_out |-> $stable(channel_select_bits) &&
        $stable(reference_mode_bit); endproperty
    a_hold: assert property (p_hold) else $error("mux moved at hold");
    c_busy: cover property ($rose(busy_out));
    c_err: cover property (pslverr);
    c_abort: cover property ($rose(chip_select_n_in) && convert_out);
endmodule
bind tacd_decoder tacd_decoder_checker u_chk (.pclk, .presetn, .psel, .penable, .paddr,
    .pslverr, .chip_select_n_in, .serial_data_oe, .busy_out, .touch_alert_out, .acquire_out,
    .convert_out, .channel_select_bits, .reference_mode_bit, .reference_power_on,
    .reference_from_drivers);

// *** tacd_host_model.sv ***
// host side serial link model: clocks control bytes in and results out
`timescale 1ns/1ns
module tacd_host_model (
    input wire logic serial_data_out,
    output logic serial_clock_in,
    output logic chip_select_n_in,
    output logic serial_data_in
);
    // clock stands low outside frames
    initial begin
        serial_clock_in = 1'b0;
        chip_select_n_in = 1'b1;
        serial_data_in = 1'b1;
    end
    // lead zeros before start bit, byte msb first, result taken on rises 10..21 counted after the lead
    task automatic xfer(input logic [7:0] cmd, input int lead, input int nclk,
                        output logic [11:0] rx);
        logic [23:0] bits;
        begin
            rx = 12'h000;
            bits = {cmd, 16'h0000} >> lead;
            chip_select_n_in = 1'b0;
            #100;
            for (int i = 0; i < nclk; i++) begin
                serial_data_in = bits[23-i];
                #80 serial_clock_in = 1'b1;
                if (i >= 9 + lead && i < 21 + lead) begin
                    rx = {rx[10:0], serial_data_out};
                end
                #80 serial_clock_in = 1'b0;
            end
        end
    endtask
    // released data line shows the inverse, not a held value; spacing >= 24 clocks
    task automatic release_link;
        chip_select_n_in = 1'b1;
        serial_data_in = ~serial_data_in;
        #200;
    endtask
endmodule

// *** touch_adc_control_byte_decoder_bench.sv ***
// self-checking bench for the control byte decoder
`timescale 1ns/1ns
module touch_adc_control_byte_decoder_bench
    import tacd_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sclk, csn, sdi, sdo, sdo_oe, xplus = 1'b1;
    logic [11:0] rx;
    int fail_count = 0, checks_done = 0;
    // rows: command bytes, panel channel Y (8'h90) differential, panel channel X (8'hde) single-ended
    logic [7:0] rows [4] = '{8'h90, 8'ha5, 8'hde, 8'h8f};
    always #4 pclk = ~pclk;
    tacd_host_model u_host (.serial_data_out(sdo), .serial_clock_in(sclk),
        .chip_select_n_in(csn), .serial_data_in(sdi));
    tacd_decoder u_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock_in(sclk), .chip_select_n_in(csn),
        .serial_data_in(sdi), .xplus_sense_in(xplus), .conv_result_in(12'ha5c),
        .serial_data_out(sdo), .serial_data_oe(sdo_oe), .busy_out(), .busy_oe(),
        .touch_alert_out(), .acquire_out(), .convert_out(), .channel_select_bits(),
        .reference_mode_bit(), .resolution_8bit(), .reference_power_on(),
        .converter_power_on(), .panel_drivers_on(), .reference_from_drivers(),
        .y_minus_ground(), .xplus_pullup_on());
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one apb transfer; a leading edge keeps back-to-back calls off one time step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n == 50) begin
            fail_count++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("conv_power", 1, u_dut.converter_power_on);
        chk("alert", 1, u_dut.touch_alert_out);
        apb(1'b0, TACD_CONFIG_OFFSET, 32'h0);
        chk("config", TACD_CONFIG_RESET, rd);
        // ordinary cases: every power code, both resolutions and reference modes
        foreach (rows[k]) begin
            u_host.xfer(rows[k], k, 24 + k, rx);
            chk("channel", rows[k][6:4], u_dut.channel_select_bits);
            chk("res8", rows[k][3], u_dut.resolution_8bit);
            chk("refmode", rows[k][2], u_dut.reference_mode_bit);
            chk("result", rows[k][3] ? 12'h0a5 : 12'ha5c, rows[k][3] ? rx[11:4] : rx);
            chk("ref_on", rows[k][1], u_dut.reference_power_on);
            chk("conv_on", rows[k][0], u_dut.converter_power_on);
            chk("yground", !rows[k][0], u_dut.y_minus_ground);
            chk("pullup", !rows[k][0], u_dut.xplus_pullup_on);
            xplus <= 1'b0;
            repeat (10) @(posedge pclk);
            chk("alert_touch", rows[k][0], u_dut.touch_alert_out);
            xplus <= 1'b1;
            apb(1'b0, TACD_COMMAND_OFFSET, 32'h0);
            chk("command", rows[k], rd[7:0]);
            u_host.release_link();
            // reference on: let it settle before the next byte
            if (rows[k][1]) begin
                repeat (50) @(posedge pclk);
            end
        end
        // overlapped start 15 clocks after the one before is taken
        u_host.xfer(8'h94, 0, 15, rx);
        u_host.xfer(8'hd3, 0, 24, rx);
        chk("overlap_result", 12'ha5c, rx);
        apb(1'b0, TACD_COMMAND_OFFSET, 32'h0);
        chk("overlap_cmd", 8'hd3, rd[7:0]);
        u_host.release_link();
        // abort mid conversion keeps the latched reference power
        u_host.xfer(8'h96, 0, 12, rx);
        u_host.release_link();
        @(posedge pclk);
        chk("abort_conv", 0, u_dut.convert_out);
        chk("abort_ref", 1, u_dut.reference_power_on);
        chk("sdo_oe", 0, sdo_oe);
        chk("busy_oe", 0, u_dut.busy_oe);
        // a further byte with the reference bit clear drops the reference
        u_host.xfer(8'h91, 0, 24, rx);
        chk("ref_off", 0, u_dut.reference_power_on);
        u_host.release_link();
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 1, err);
        apb(1'b1, TACD_CONFIG_OFFSET, 32'h0);
        apb(1'b0, TACD_CONFIG_OFFSET, 32'h0);
        chk("cfg_off", 0, rd);
        stop_test();
    end
    // cut a hang short
    initial begin
        #400000;
        fail_count++;
        stop_test();
    end
endmodule
